// ### hw/ipb_pkg.sv
// Package: register map, reset values and field layout of the priority bank
package ipb_pkg;

  localparam int unsigned IPB_NREG = 6;
  localparam int unsigned IPB_NSRC = 20;
  localparam int unsigned IPB_FW   = 3;
  localparam int unsigned IPB_AW   = 8;

  // Byte addresses on the register bus
  localparam logic [IPB_AW-1:0] IPB_OFF_TIMER2_OC2_IC2_DMA0 = 8'h00;
  localparam logic [IPB_AW-1:0] IPB_OFF_UART1RX_SPI1_TIMER3 = 8'h04;
  localparam logic [IPB_AW-1:0] IPB_OFF_DMA1_ADC1_UART1TX   = 8'h08;
  localparam logic [IPB_AW-1:0] IPB_OFF_CHANGE_CMP_I2C1     = 8'h0c;
  localparam logic [IPB_AW-1:0] IPB_OFF_EXTERNAL1           = 8'h10;
  localparam logic [IPB_AW-1:0] IPB_OFF_TIMER4_OC4_OC3_DMA2 = 8'h14;

  localparam logic [2:0] IPB_MISS = 3'h7;

  typedef logic [IPB_FW-1:0]  ipb_prio_t;
  typedef logic [5:0][15:0]   ipb_bank_t;

  // Implemented bits per register, index 5 first
  localparam ipb_bank_t IPB_MASK = {16'h7777, 16'h0007, 16'h7777, 16'h0777, 16'h7777, 16'h7777};
  // Every implemented field resets to level 4
  localparam ipb_bank_t IPB_RST  = {16'h4444, 16'h0004, 16'h4444, 16'h0444, 16'h4444, 16'h4444};

  localparam ipb_prio_t IPB_PRIO_OFF = 3'h0;
  localparam ipb_prio_t IPB_PRIO_MIN = 3'h1;
  localparam ipb_prio_t IPB_PRIO_MAX = 3'h7;

  localparam int unsigned IPB_F3 = 12;
  localparam int unsigned IPB_F2 = 8;
  localparam int unsigned IPB_F1 = 4;
  localparam int unsigned IPB_F0 = 0;

  localparam logic [1:0] IPB_RESP_OKAY   = 2'h0;
  localparam logic [1:0] IPB_RESP_SLVERR = 2'h2;

  typedef struct packed {
    ipb_prio_t timer2_prio;
    ipb_prio_t outcmp2_prio;
    ipb_prio_t incap2_prio;
    ipb_prio_t dma_ch0_prio;
    ipb_prio_t uart1_rx_prio;
    ipb_prio_t spi1_tx_prio;
    ipb_prio_t spi1_general_prio;
    ipb_prio_t timer3_prio;
    ipb_prio_t dma_ch1_prio;
    ipb_prio_t adc1_prio;
    ipb_prio_t uart1_tx_prio;
    ipb_prio_t change_notify_prio;
    ipb_prio_t comparator_prio;
    ipb_prio_t i2c1_master_prio;
    ipb_prio_t i2c1_slave_prio;
    ipb_prio_t ext_irq1_prio;
    ipb_prio_t timer4_prio;
    ipb_prio_t outcmp4_prio;
    ipb_prio_t outcmp3_prio;
    ipb_prio_t dma_ch2_prio;
  } ipb_prio_s;

endpackage : ipb_pkg

// ### hw/ipb_bank.sv
// Interrupt priority bank: six priority registers behind an AXI4-Lite slave
// How it works
// R1 - Field 111 ranks source at top level 7
// R2 - Field 001 is level 1, others in between
// R3 - Field 000 disables the source entirely
// R4 - Reset loads every field with 100
// R5 - Unimplemented bits read zero, ignore writes
// R6 - Register 1: timer2, oc2, ic2, dma0 fields
// R7 - Register 2: uart1 rx, spi1 tx/general, timer3
// R8 - Register 3: dma1, adc1, uart1 tx
// R9 - Register 4: change notify, comparator, i2c1 pair
// R10 - Register 5: external interrupt 1 only
// R11 - Register 6: timer4, oc4, oc3, dma2 fields
// R12 - Fields drive arbitration, writes visible next cycle
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none

module ipb_bank (
  input  wire logic                       i_clk,
  input  wire logic                       i_nrst,
  input  wire logic [ipb_pkg::IPB_AW-1:0] i_awaddr,
  input  wire logic                       i_awvalid,
  output logic                            o_awready,
  input  wire logic [31:0]                i_wdata,
  input  wire logic [3:0]                 i_wstrb,
  input  wire logic                       i_wvalid,
  output logic                            o_wready,
  output logic [1:0]                      o_bresp,
  output logic                            o_bvalid,
  input  wire logic                       i_bready,
  input  wire logic [ipb_pkg::IPB_AW-1:0] i_araddr,
  input  wire logic                       i_arvalid,
  output logic                            o_arready,
  output logic [31:0]                     o_rdata,
  output logic [1:0]                      o_rresp,
  output logic                            o_rvalid,
  input  wire logic                       i_rready,
  output ipb_pkg::ipb_prio_s              o_prio,
  output logic [ipb_pkg::IPB_NSRC-1:0]    o_src_en
);
  import ipb_pkg::*;

  ipb_bank_t          bank_q;
  ipb_bank_t          bank_d;
  logic [IPB_NSRC-1:0] en_q;
  logic               aw_held_q;
  logic [IPB_AW-1:0]  awaddr_q;
  logic               w_held_q;
  logic [15:0]        wdata_q;
  logic [1:0]         wstrb_q;
  logic               awready_q;
  logic               wready_q;
  logic               bvalid_q;
  logic [1:0]         bresp_q;
  logic               arready_q;
  logic               rvalid_q;
  logic [31:0]        rdata_q;
  logic [1:0]         rresp_q;
  logic               wr_go;
  logic [2:0]         wr_idx;
  logic [2:0]         rd_idx;

  function automatic logic [2:0] reg_index(input logic [IPB_AW-1:0] a);
    logic [2:0] idx;
    if (a == IPB_OFF_TIMER2_OC2_IC2_DMA0) begin
      idx = 3'h0;
    end else if (a == IPB_OFF_UART1RX_SPI1_TIMER3) begin
      idx = 3'h1;
    end else if (a == IPB_OFF_DMA1_ADC1_UART1TX) begin
      idx = 3'h2;
    end else if (a == IPB_OFF_CHANGE_CMP_I2C1) begin
      idx = 3'h3;
    end else if (a == IPB_OFF_EXTERNAL1) begin
      idx = 3'h4;
    end else if (a == IPB_OFF_TIMER4_OC4_OC3_DMA2) begin
      idx = 3'h5;
    end else begin
      idx = IPB_MISS;
    end
    return idx;
  endfunction : reg_index

  // Fields placed per register layout
  function automatic ipb_prio_s unpack(input ipb_bank_t b);
    ipb_prio_s p;
    p.timer2_prio        = b[0][IPB_F3 +: IPB_FW]; // see R6
    p.outcmp2_prio       = b[0][IPB_F2 +: IPB_FW];
    p.incap2_prio        = b[0][IPB_F1 +: IPB_FW];
    p.dma_ch0_prio       = b[0][IPB_F0 +: IPB_FW];
    p.uart1_rx_prio      = b[1][IPB_F3 +: IPB_FW]; // see R7
    p.spi1_tx_prio       = b[1][IPB_F2 +: IPB_FW];
    p.spi1_general_prio  = b[1][IPB_F1 +: IPB_FW];
    p.timer3_prio        = b[1][IPB_F0 +: IPB_FW];
    p.dma_ch1_prio       = b[2][IPB_F2 +: IPB_FW]; // see R8
    p.adc1_prio          = b[2][IPB_F1 +: IPB_FW];
    p.uart1_tx_prio      = b[2][IPB_F0 +: IPB_FW];
    p.change_notify_prio = b[3][IPB_F3 +: IPB_FW]; // see R9
    p.comparator_prio    = b[3][IPB_F2 +: IPB_FW];
    p.i2c1_master_prio   = b[3][IPB_F1 +: IPB_FW];
    p.i2c1_slave_prio    = b[3][IPB_F0 +: IPB_FW];
    p.ext_irq1_prio      = b[4][IPB_F0 +: IPB_FW]; // see R10
    p.timer4_prio        = b[5][IPB_F3 +: IPB_FW]; // see R11
    p.outcmp4_prio       = b[5][IPB_F2 +: IPB_FW];
    p.outcmp3_prio       = b[5][IPB_F1 +: IPB_FW];
    p.dma_ch2_prio       = b[5][IPB_F0 +: IPB_FW];
    return p;
  endfunction : unpack

  // A source takes part in arbitration unless its level is zero
  function automatic logic [IPB_NSRC-1:0] enables(input ipb_prio_s p);
    logic [IPB_NSRC*IPB_FW-1:0] flat;
    logic [IPB_NSRC-1:0]        en;
    flat = p;
    for (int i = 0; i < IPB_NSRC; i++) begin
      en[i] = (flat[i*IPB_FW +: IPB_FW] != IPB_PRIO_OFF); // see R3
    end
    return en;
  endfunction : enables

  assign wr_go  = aw_held_q && w_held_q && !bvalid_q;
  assign wr_idx = reg_index(awaddr_q);
  assign rd_idx = reg_index(i_araddr);

  // Write address channel
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
      awready_q <= 1'b0;
    end else if (i_awvalid && awready_q) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= i_awaddr;
      awready_q <= 1'b0;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end else if (!aw_held_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  // Write data channel; only the low half carries register bits
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      w_held_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
      wready_q <= 1'b0;
    end else if (i_wvalid && wready_q) begin
      w_held_q <= 1'b1;
      wdata_q  <= i_wdata[15:0];
      wstrb_q  <= i_wstrb[1:0];
      wready_q <= 1'b0;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end else if (!w_held_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= IPB_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_idx == IPB_MISS) ? IPB_RESP_SLVERR : IPB_RESP_OKAY;
    end else if (bvalid_q && i_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Byte-lane merge, masked to implemented bits
  always_comb begin
    bank_d = bank_q;
    if (wr_go && wr_idx != IPB_MISS) begin
      for (int b = 0; b < 2; b++) begin
        if (wstrb_q[b]) begin
          bank_d[wr_idx][b*8 +: 8] = wdata_q[b*8 +: 8];
        end
      end
      bank_d[wr_idx] = bank_d[wr_idx] & IPB_MASK[wr_idx]; // see R5
    end
  end

  // Priority storage
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bank_q <= IPB_RST; // see R4
    end else begin
      bank_q <= bank_d; // see R12
    end
  end

  // Enable flags track the stored fields in the same cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      en_q <= '1;
    end else begin
      en_q <= enables(unpack(bank_d)); // see R3
    end
  end

  // Read channel
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= IPB_RESP_OKAY;
    end else if (i_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      if (rd_idx == IPB_MISS) begin
        rdata_q <= '0;
        rresp_q <= IPB_RESP_SLVERR;
      end else begin
        rdata_q <= {16'h0000, bank_q[rd_idx]}; // see R5
        rresp_q <= IPB_RESP_OKAY;
      end
    end else if (rvalid_q && i_rready) begin
      rvalid_q <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  assign o_awready = awready_q;
  assign o_wready  = wready_q;
  assign o_bvalid  = bvalid_q;
  assign o_bresp   = bresp_q;
  assign o_arready = arready_q;
  assign o_rvalid  = rvalid_q;
  assign o_rdata   = rdata_q;
  assign o_rresp   = rresp_q;
  assign o_prio    = unpack(bank_q); // see R1 see R2 see R12
  assign o_src_en  = en_q;

  // Checks
  logic fresh_q;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fresh_q <= 1'b0;
    end else begin
      fresh_q <= 1'b1;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence wr_to(logic [2:0] k);
    wr_go && wr_idx == k && wstrb_q == 2'h3;
  endsequence

  reset_level_a: assert property (!fresh_q |-> o_prio == unpack(IPB_RST) && &o_src_en) // see R4
    else $error("fields not at level 4 after reset");

  unimpl_zero_a: assert property ((bank_q & ~IPB_MASK) == '0 && o_rdata[31:16] == 16'h0000) // see R5
    else $error("unimplemented bit set");

  disable_flag_a: assert property (o_src_en == enables(o_prio)) // see R3
    else $error("enable flag does not match field");

  reg1_write_a: assert property (wr_to(0) |=> o_prio.timer2_prio == $past(wdata_q[14:12]) && o_bvalid) // see R6
    else $error("timer2 field not written");

  reg2_write_a: assert property (wr_to(1) |=> o_prio.spi1_tx_prio == $past(wdata_q[10:8])) // see R7
    else $error("spi1 transmit field not written");

  reg3_write_a: assert property (wr_to(2) |=> o_prio.dma_ch1_prio == $past(wdata_q[10:8]) ##1 bank_q[2][15:11] == 5'h00) // see R8
    else $error("dma1 field or upper bits wrong");

  reg4_write_a: assert property (wr_to(3) |=> o_prio.i2c1_master_prio == $past(wdata_q[6:4])) // see R9
    else $error("i2c1 master field not written");

  reg5_write_a: assert property (wr_to(4) |=> o_prio.ext_irq1_prio == $past(wdata_q[2:0]) && bank_q[4][15:3] == '0) // see R10
    else $error("external 1 field wrong");

  reg6_write_a: assert property (wr_to(5) |=> o_prio.dma_ch2_prio == $past(wdata_q[2:0]) && o_src_en[0] == ($past(wdata_q[2:0]) != 3'h0)) // see R11
    else $error("dma2 field or enable wrong");

  level_readback_a: assert property (i_arvalid && arready_q && rd_idx == 3'h0 |=> o_rvalid && o_rdata[14:12] == $past(o_prio.timer2_prio)) // see R1 see R2
    else $error("timer2 level does not read back");

  idle_hold_a: assert property (!wr_go |=> $stable(o_prio)) // see R12
    else $error("fields changed without a write");

  enable_order_a: assert property ( // see R3
    o_src_en[19] == (o_prio.timer2_prio != IPB_PRIO_OFF) &&
    o_src_en[4] == (o_prio.ext_irq1_prio != IPB_PRIO_OFF) &&
    o_src_en[0] == (o_prio.dma_ch2_prio != IPB_PRIO_OFF))
    else $error("enable flag in wrong position");

  low_byte_only_a: assert property (wr_go && wr_idx == 3'h0 && wstrb_q == 2'h1 |=> // see R6
    o_prio.timer2_prio == $past(o_prio.timer2_prio) && o_prio.dma_ch0_prio == $past(wdata_q[2:0]))
    else $error("byte strobe not honoured");

  miss_write_a: assert property (wr_go && wr_idx == IPB_MISS |=> o_bresp == IPB_RESP_SLVERR && $stable(o_prio)) // see R12
    else $error("unmapped write changed a field");

  miss_read_a: assert property (i_arvalid && arready_q && rd_idx == IPB_MISS |=> // see R5
    o_rresp == IPB_RESP_SLVERR && o_rdata == 32'h00000000)
    else $error("unmapped read not refused");

  reg5_read_a: assert property (i_arvalid && arready_q && rd_idx == 3'h4 |=> o_rdata[15:3] == 13'h0000) // see R10
    else $error("external 1 unused bits read back");

endmodule : ipb_bank

`default_nettype wire

// ### sim/ipb_testbench.sv
// Self-checking testbench for the interrupt priority bank
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import ipb_pkg::*;

  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [3:0]  s;
    logic [1:0]  r;
  } ipb_row_s;

  logic        i_clk;
  logic        i_nrst;
  logic [7:0]  i_awaddr;
  logic        i_awvalid;
  logic        o_awready;
  logic [31:0] i_wdata;
  logic [3:0]  i_wstrb;
  logic        i_wvalid;
  logic        o_wready;
  logic [1:0]  o_bresp;
  logic        o_bvalid;
  logic        i_bready;
  logic [7:0]  i_araddr;
  logic        i_arvalid;
  logic        o_arready;
  logic [31:0] o_rdata;
  logic [1:0]  o_rresp;
  logic        o_rvalid;
  logic        i_rready;
  ipb_prio_s   o_prio;
  logic [19:0] o_src_en;
  logic [15:0] model [6];
  logic [31:0] rd;
  logic [1:0]  rs;
  int          failures;
  int          samples_checked;

  // Distinct field values expose swapped or shifted fields
  ipb_row_s rows [13] = '{
    '{8'h00, 32'hffffffff, 4'hf, 2'h0}, '{8'h04, 32'h00007531, 4'h3, 2'h0},
    '{8'h08, 32'h0000ffff, 4'h3, 2'h0}, '{8'h0c, 32'h00001357, 4'h3, 2'h0},
    '{8'h10, 32'hffffffff, 4'h3, 2'h0}, '{8'h14, 32'h00002461, 4'h3, 2'h0},
    '{8'h00, 32'h00001111, 4'h3, 2'h0}, '{8'h00, 32'h00000000, 4'h1, 2'h0},
    '{8'h14, 32'h00000000, 4'h3, 2'h0}, '{8'h18, 32'h0000ffff, 4'h3, 2'h2},
    '{8'hfc, 32'h00001234, 4'h3, 2'h2}, '{8'h10, 32'h00000000, 4'h3, 2'h0},
    '{8'h04, 32'h0000ffff, 4'h2, 2'h0}};

  ipb_bank uut (.i_clk, .i_nrst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid,
    .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
    .o_rresp, .o_rvalid, .i_rready, .o_prio, .o_src_en);

  always #10 i_clk = ~i_clk;

  task automatic stop_test();
    $display("Counts: %0d compared, %0d mismatched", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic check_outs();
    logic [59:0] p;
    logic [19:0] e;
    p = '0;
    e = '0;
    for (int r = 0; r < 6; r++) begin
      for (int f = 3; f >= 0; f--) begin
        if (IPB_MASK[r][f*4+:3] != 3'h0) begin
          p = {p[56:0], model[r][f*4+:3]};
          e = {e[18:0], model[r][f*4+:3] != 3'h0};
        end
      end
    end
    chk("prio", o_prio, p);
    chk("src_en", o_src_en, e);
  endtask : check_outs

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= s;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    r = 2'h3;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) begin
        r = o_bresp;
        i_bready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      failures++;
      stop_test();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    d = '0;
    r = 2'h3;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) begin
        d = o_rdata;
        r = o_rresp;
        i_rready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      failures++;
      stop_test();
    end
  endtask : axi_rd

  task automatic read_all(input string nm);
    for (int i = 0; i < 6; i++) begin
      axi_rd(8'(i * 4), rd, rs);
      chk("rdata", rd, {16'h0, model[i]});
      chk("rresp", rs, IPB_RESP_OKAY);
    end
    check_outs();
    $display("Test %s done", nm);
  endtask : read_all

  task automatic do_reset();
    i_nrst <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    for (int i = 0; i < 6; i++) model[i] = IPB_RST[i];
  endtask : do_reset

  initial begin
    logic [15:0] bm;
    int          k;
    {i_clk, i_nrst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    {i_awaddr, i_araddr, i_wdata, i_wstrb} = '0;
    failures = 0;
    samples_checked = 0;
    do_reset();
    read_all("reset_values");
    foreach (rows[i]) begin
      k = int'(rows[i].a[7:2]);
      bm = {{8{rows[i].s[1]}}, {8{rows[i].s[0]}}};
      if (rows[i].a < 8'h18) model[k] = (model[k] & ~bm) | (rows[i].d[15:0] & bm & IPB_MASK[k]);
      axi_wr(rows[i].a, rows[i].d, rows[i].s, rs);
      chk("bresp", rs, rows[i].r);
      check_outs();
      axi_rd(rows[i].a, rd, rs);
      chk("rresp", rs, rows[i].r);
      chk("rdata", rd, (rows[i].a < 8'h18) ? {16'h0, model[k]} : 32'h0);
    end
    $display("Test table_rows done");
    read_all("after_rows");
    // Every level code in every field of the first and fifth registers
    for (int v = 0; v < 8; v++) begin
      model[0] = {4{1'b0, 3'(v)}};
      model[4] = {13'h0, 3'(v)};
      axi_wr(IPB_OFF_TIMER2_OC2_IC2_DMA0, {16'h0, model[0]}, 4'h3, rs);
      chk("bresp", rs, IPB_RESP_OKAY);
      axi_wr(IPB_OFF_EXTERNAL1, 32'h0000fff8 | 32'(v), 4'h3, rs);
      chk("bresp", rs, IPB_RESP_OKAY);
      check_outs();
    end
    $display("Test level_codes done");
    // Reset in mid-run restores every field to level 4
    do_reset();
    read_all("second_reset");
    stop_test();
  end

endmodule : testbench

`default_nettype wire
